//--- verilog/pssc_pkg.sv
// constants, states and register map for the press stroke safety control
package pssc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_KHZ       = 200000;  // 200 MHz system clock
  localparam int unsigned FLASH_HALF_MS = 250;     // half period of the interrupted-stroke flash
  localparam int unsigned FLASH_HALF_CYCLES_DEF = FLASH_HALF_MS * CLK_KHZ;
  localparam int unsigned FLASH_CNT_W   = 26;

  // ****************************************
  // fault codes, shown as two BCD digits
  // ****************************************
  localparam logic [7:0] FAULT_NONE                = 8'h00;
  localparam logic [7:0] ESTOP_FAULT_CODE          = 8'h13;
  localparam logic [7:0] CLUTCH_AIR_FAULT_CODE     = 8'h48;
  localparam logic [7:0] USER_INPUT_ONE_FAULT_CODE = 8'h51;
  localparam logic [7:0] OVERRUN_FAULT_CODE_LOW    = 8'h80;  // overrun sensor tripped
  localparam logic [7:0] OVERRUN_FAULT_CODE_STOP   = 8'h81;  // ram drifted past top stop
  localparam logic [7:0] OVERRUN_FAULT_CODE_HIGH   = 8'h89;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam int unsigned AVS_ADDR_W = 4;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_COUNT  = 4'h8;

  // control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_ALT_BIT    = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h1;  // run permitted, F-range display

  // status register fields
  localparam int unsigned STAT_STATE_LSB  = 0;
  localparam int unsigned STAT_CLUTCH_BIT = 3;
  localparam int unsigned STAT_FAULT_BIT  = 4;
  localparam int unsigned STAT_LEFT_BIT   = 5;
  localparam int unsigned STAT_CODE_LSB   = 8;

  // ****************************************
  // stroke sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE        = 3'b000,  // stopped at top dead center
    ST_SINGLE      = 3'b001,  // single stroke in progress
    ST_INCH        = 3'b010,  // hold-to-run inching
    ST_INTERRUPTED = 3'b011,  // stopped mid-stroke
    ST_WAIT_REL    = 3'b100   // stroke done, waiting for both buttons released
  } pssc_state_t;

endpackage : pssc_pkg

//--- verilog/pssc_core.sv
// stroke sequencer, fault latch and register slave for the press safety control
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ps

module pssc_core
  import pssc_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYCLES = FLASH_HALF_CYCLES_DEF
) (
  input  wire logic                  I_CLK_SYS,
  input  wire logic                  I_RESET,
  input  wire logic                  I_MODE_INCH,
  input  wire logic                  I_MODE_SINGLE,
  input  wire logic                  I_MODE_REPEAT,
  input  wire logic                  I_ESTOP_CH1,
  input  wire logic                  I_ESTOP_CH2,
  input  wire logic                  I_CLUTCH_AIR_OK,
  input  wire logic                  I_USER_IN1_OK,
  input  wire logic                  I_CURTAIN_A_CH1,
  input  wire logic                  I_CURTAIN_A_CH2,
  input  wire logic                  I_CURTAIN_B_CH1,
  input  wire logic                  I_CURTAIN_B_CH2,
  input  wire logic                  I_RUN_LEFT,
  input  wire logic                  I_RUN_RIGHT,
  input  wire logic                  I_RESET_SELECT,
  input  wire logic                  I_AT_TDC,
  input  wire logic                  I_DOWNSTROKE,
  input  wire logic                  I_OVERRUN,
  input  wire logic [AVS_ADDR_W-1:0] I_AVS_ADDRESS,
  input  wire logic                  I_AVS_READ,
  input  wire logic                  I_AVS_WRITE,
  input  wire logic [31:0]           I_AVS_WRITEDATA,
  input  wire logic [3:0]            I_AVS_BYTEENABLE,
  output logic      [31:0]           O_AVS_READDATA,
  output logic                       O_AVS_WAITREQUEST,
  output logic                       O_CLUTCH_ENGAGE,
  output logic                       O_INTERRUPTED_LED,
  output logic                       O_INCH_LED,
  output logic                       O_SINGLE_LED,
  output logic      [7:0]            O_FAULT_CODE,
  output logic                       O_FAULT_ALT,
  output logic                       O_FAULT_ACTIVE
);

  // ****************************************
  // helper functions
  // ****************************************

  // true while the condition behind a latched code other than OVERRUN_FAULT_CODE_STOP is still present
  function automatic logic fault_cause(input logic [7:0] code,
                                       input logic       estop_ok,
                                       input logic       air_ok,
                                       input logic       user_ok,
                                       input logic       overrun);
    logic cause;
    cause = 1'b0;
    case (code)
      ESTOP_FAULT_CODE:          cause = ~estop_ok;
      CLUTCH_AIR_FAULT_CODE:     cause = ~air_ok;
      USER_INPUT_ONE_FAULT_CODE: cause = ~user_ok;
      OVERRUN_FAULT_CODE_LOW:    cause = overrun;
      default:                   cause = 1'b0;
    endcase
    return cause;
  endfunction : fault_cause

  // true for a running state in which the clutch is engaged
  function automatic logic is_running(input pssc_state_t st);
    return (st == ST_SINGLE) || (st == ST_INCH);
  endfunction : is_running

  // ****************************************
  // state
  // ****************************************
  pssc_state_t            state_reg,   state_next;
  logic                   left_tdc_reg, left_tdc_next;
  logic                   clutch_reg,  clutch_next;
  logic [7:0]             fault_reg,   fault_next;
  logic [FLASH_CNT_W-1:0] flash_cnt_reg, flash_cnt_next;
  logic                   flash_reg,   flash_next;
  logic                   led_int_reg, led_int_next;
  logic                   led_inch_reg, led_inch_next;
  logic                   led_single_reg, led_single_next;
  logic [1:0]             ctrl_reg,    ctrl_next;
  logic [31:0]            count_reg,   count_next;
  logic                   ack_reg,     ack_next;
  logic [31:0]            rdata_reg,   rdata_next;

  logic       estop_ok;
  logic       curtains_clear;
  logic       run_both;
  logic       mode_inch;
  logic       mode_single;
  logic       hard_ok;
  logic [7:0] new_fault;
  logic       avs_req;

  // ****************************************
  // input qualification
  // ****************************************

  // both channels must read active; a single open channel counts as a stop
  assign estop_ok       = I_ESTOP_CH1 & I_ESTOP_CH2;
  // any low channel on either curtain counts as obstructed
  assign curtains_clear = I_CURTAIN_A_CH1 & I_CURTAIN_A_CH2
                        & I_CURTAIN_B_CH1 & I_CURTAIN_B_CH2;
  assign run_both       = I_RUN_LEFT & I_RUN_RIGHT;
  // a selector reading two positions at once is treated as no mode at all
  assign mode_inch      = I_MODE_INCH & ~I_MODE_SINGLE & ~I_MODE_REPEAT;
  assign mode_single    = I_MODE_SINGLE & ~I_MODE_INCH & ~I_MODE_REPEAT;
  // permissives that must hold for the clutch to stay in
  assign hard_ok        = estop_ok & I_CLUTCH_AIR_OK & I_USER_IN1_OK
                        & (fault_reg == FAULT_NONE) & ctrl_reg[CTRL_ENABLE_BIT];

  // ****************************************
  // fault detection, priority e-stop first
  // ****************************************
  always_comb begin
    new_fault = FAULT_NONE;
    if (!estop_ok) begin
      new_fault = ESTOP_FAULT_CODE;
    end else if (I_OVERRUN) begin
      new_fault = OVERRUN_FAULT_CODE_LOW;
    end else if (state_reg == ST_WAIT_REL && !I_AT_TDC) begin  // parked ram crept off top
      new_fault = OVERRUN_FAULT_CODE_STOP;
    end else if (run_both && !I_CLUTCH_AIR_OK) begin
      new_fault = CLUTCH_AIR_FAULT_CODE;
    end else if (run_both && !I_USER_IN1_OK) begin
      new_fault = USER_INPUT_ONE_FAULT_CODE;
    end
  end

  // ****************************************
  // next values: sequencer, faults, stroke count, clutch
  // ****************************************
  always_comb begin
    state_next      = state_reg;
    left_tdc_next   = left_tdc_reg;
    fault_next      = fault_reg;
    count_next      = count_reg;
    // clear first so a fault arriving in the same cycle is kept
    if (fault_reg != FAULT_NONE && I_RESET_SELECT &&
        !fault_cause(fault_reg, estop_ok, I_CLUTCH_AIR_OK, I_USER_IN1_OK, I_OVERRUN)) begin
      fault_next = FAULT_NONE;
    end
    if (new_fault != FAULT_NONE &&
        (fault_next == FAULT_NONE || new_fault == ESTOP_FAULT_CODE)) begin
      fault_next = new_fault;
    end
    case (state_reg)
      ST_IDLE: begin
        // start needs clear curtains as well as every permissive
        if (run_both && hard_ok && curtains_clear) begin
          if (mode_single) begin
            state_next = ST_SINGLE;
          end else if (mode_inch) begin
            state_next = ST_INCH;
          end
        end
      end
      ST_SINGLE, ST_INCH: begin
        if (!I_AT_TDC) begin
          left_tdc_next = 1'b1;
        end
        if (!run_both || !hard_ok) begin
          state_next = ST_INTERRUPTED;
        end else if (!curtains_clear && I_DOWNSTROKE) begin
          state_next = ST_INTERRUPTED;
        end else if (left_tdc_reg && I_AT_TDC) begin
          state_next    = ST_WAIT_REL;
          left_tdc_next = 1'b0;
          count_next    = count_reg + 32'h1;
        end
      end
      ST_INTERRUPTED: begin
        // upstroke restart is allowed with a blocked curtain, downstroke is not
        if (run_both && hard_ok && (curtains_clear || !I_DOWNSTROKE)) begin
          if (mode_single) begin
            state_next = ST_SINGLE;
          end else if (mode_inch) begin
            state_next = ST_INCH;
          end
        end
      end
      ST_WAIT_REL: begin
        // a held pair of buttons must not start a second stroke
        if (!I_RUN_LEFT && !I_RUN_RIGHT) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_INTERRUPTED;
      end
    endcase
    clutch_next = is_running(state_next);
  end

  // ****************************************
  // indicator flash timer and lamps
  // ****************************************
  always_comb begin
    flash_cnt_next = flash_cnt_reg + 1'b1;
    flash_next     = flash_reg;
    if (flash_cnt_reg == FLASH_CNT_W'(FLASH_HALF_CYCLES - 1)) begin
      flash_cnt_next = '0;
      flash_next     = ~flash_reg;
    end
    // flashing after an interruption wins over the steady inch light
    if (state_reg == ST_INTERRUPTED) begin
      led_int_next = flash_reg;
    end else begin
      led_int_next = mode_inch;
    end
    led_inch_next   = mode_inch;
    led_single_next = mode_single;
  end

  // ****************************************
  // avalon slave: one wait cycle, data from a flop
  // ****************************************
  assign avs_req = I_AVS_READ | I_AVS_WRITE;

  always_comb begin
    ack_next   = avs_req & ~ack_reg;
    rdata_next = rdata_reg;
    ctrl_next  = ctrl_reg;
    if (avs_req && !ack_reg && I_AVS_READ) begin
      case (I_AVS_ADDRESS)
        REG_CTRL: begin
          rdata_next = {30'h0, ctrl_reg};
        end
        REG_STATUS: begin
          rdata_next = '0;
          rdata_next[STAT_STATE_LSB +: 3] = state_reg;
          rdata_next[STAT_CLUTCH_BIT]     = clutch_reg;
          rdata_next[STAT_FAULT_BIT]      = (fault_reg != FAULT_NONE);
          rdata_next[STAT_LEFT_BIT]       = left_tdc_reg;
          rdata_next[STAT_CODE_LSB +: 8]  = fault_reg;
        end
        REG_COUNT: begin
          rdata_next = count_reg;
        end
        default: begin
          rdata_next = 32'h0;  // unmapped reads return zero
        end
      endcase
    end
    // a write lands on the edge after waitrequest drops, the one that completes the transfer
    if (I_AVS_WRITE && ack_reg && I_AVS_ADDRESS == REG_CTRL && I_AVS_BYTEENABLE[0]) begin
      ctrl_next = I_AVS_WRITEDATA[1:0];
    end
  end

  assign O_AVS_WAITREQUEST = avs_req & ~ack_reg;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      state_reg      <= ST_IDLE;
      left_tdc_reg   <= 1'b0;
      clutch_reg     <= 1'b0;
      fault_reg      <= FAULT_NONE;
      flash_cnt_reg  <= '0;
      flash_reg      <= 1'b0;
      led_int_reg    <= 1'b0;
      led_inch_reg   <= 1'b0;
      led_single_reg <= 1'b0;
      ctrl_reg       <= CTRL_RESET;
      count_reg      <= 32'h0;
      ack_reg        <= 1'b0;
      rdata_reg      <= 32'h0;
    end else begin
      state_reg      <= state_next;
      left_tdc_reg   <= left_tdc_next;
      clutch_reg     <= clutch_next;
      fault_reg      <= fault_next;
      flash_cnt_reg  <= flash_cnt_next;
      flash_reg      <= flash_next;
      led_int_reg    <= led_int_next;
      led_inch_reg   <= led_inch_next;
      led_single_reg <= led_single_next;
      ctrl_reg       <= ctrl_next;
      count_reg      <= count_next;
      ack_reg        <= ack_next;
      rdata_reg      <= rdata_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign O_AVS_READDATA    = rdata_reg;
  assign O_CLUTCH_ENGAGE   = clutch_reg;
  assign O_INTERRUPTED_LED = led_int_reg;
  assign O_INCH_LED        = led_inch_reg;
  assign O_SINGLE_LED      = led_single_reg;
  assign O_FAULT_CODE      = fault_reg;
  // alternate range only labels overrun codes, others keep their prefix
  assign O_FAULT_ALT       = ctrl_reg[CTRL_ALT_BIT] && fault_reg >= OVERRUN_FAULT_CODE_LOW
                          && fault_reg <= OVERRUN_FAULT_CODE_HIGH;
  assign O_FAULT_ACTIVE    = (fault_reg != FAULT_NONE);

endmodule : pssc_core

//--- bench/pssc_ram_model.sv
// behavioural ram and crank sensors that follow the clutch output
`timescale 1ns/1ps
module pssc_ram_model (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_clutch,
  input  wire logic i_creep,
  output logic      o_at_tdc,
  output logic      o_downstroke
);
  logic [3:0] pos_reg;

  // crank steps once per cycle while engaged; creep models a slipping brake
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pos_reg <= 4'h0;
    end else if (i_clutch || i_creep) begin
      pos_reg <= pos_reg + 4'h1;
    end
  end

  // top zone spans two steps so a one-cycle brake lag still stops inside it
  assign o_at_tdc     = (pos_reg < 4'h2);
  assign o_downstroke = (pos_reg >= 4'h2) && (pos_reg <= 4'h8);
endmodule : pssc_ram_model

//--- bench/pssc_checker.sv
// port-level assertions for the press stroke safety control
`timescale 1ns/1ps
module pssc_checker
  import pssc_pkg::*;
(
  input wire logic       I_CLK_SYS,
  input wire logic       I_RESET,
  input wire logic       I_MODE_INCH,
  input wire logic       I_MODE_SINGLE,
  input wire logic       I_ESTOP_CH1,
  input wire logic       I_ESTOP_CH2,
  input wire logic       I_CLUTCH_AIR_OK,
  input wire logic       I_USER_IN1_OK,
  input wire logic       I_CURTAIN_A_CH1,
  input wire logic       I_CURTAIN_A_CH2,
  input wire logic       I_CURTAIN_B_CH1,
  input wire logic       I_CURTAIN_B_CH2,
  input wire logic       I_RUN_LEFT,
  input wire logic       I_RUN_RIGHT,
  input wire logic       I_RESET_SELECT,
  input wire logic       I_AT_TDC,
  input wire logic       I_DOWNSTROKE,
  input wire logic       I_OVERRUN,
  input wire logic       O_CLUTCH_ENGAGE,
  input wire logic       O_INCH_LED,
  input wire logic [7:0] O_FAULT_CODE,
  input wire logic       O_FAULT_ACTIVE
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);

  // short names for the conditions the rules keep returning to
  wire logic both    = I_RUN_LEFT && I_RUN_RIGHT;
  wire logic stop    = !I_ESTOP_CH1 || !I_ESTOP_CH2;
  wire logic blocked = !(I_CURTAIN_A_CH1 && I_CURTAIN_A_CH2 && I_CURTAIN_B_CH1 && I_CURTAIN_B_CH2);
  wire logic req     = both && !stop && !O_FAULT_ACTIVE && !O_CLUTCH_ENGAGE && I_AT_TDC
                       && (I_MODE_SINGLE || I_MODE_INCH);

  chk_start_perm: assert property ($rose(O_CLUTCH_ENGAGE) |-> $past(both && !stop
    && I_CLUTCH_AIR_OK && I_USER_IN1_OK && !O_FAULT_ACTIVE)) else $error("start without permit");
  chk_estop_code: assert property (stop |=> O_FAULT_CODE == ESTOP_FAULT_CODE)
    else $error("stop code missing");
  chk_estop_halt: assert property (stop |=> !O_CLUTCH_ENGAGE)
    else $error("clutch on with stop");
  chk_air_refuse: assert property (req && !I_CLUTCH_AIR_OK && I_USER_IN1_OK
    |=> O_FAULT_CODE == CLUTCH_AIR_FAULT_CODE && !O_CLUTCH_ENGAGE) else $error("air refusal");
  chk_user_refuse: assert property (req && I_CLUTCH_AIR_OK && !I_USER_IN1_OK
    |=> O_FAULT_CODE == USER_INPUT_ONE_FAULT_CODE && !O_CLUTCH_ENGAGE) else $error("user refusal");
  chk_blocked_start: assert property (I_MODE_SINGLE && blocked && I_AT_TDC && !O_CLUTCH_ENGAGE
    |=> !O_CLUTCH_ENGAGE) else $error("start while blocked");
  chk_curtain_stop: assert property (O_CLUTCH_ENGAGE && I_DOWNSTROKE && blocked
    |=> !O_CLUTCH_ENGAGE) else $error("no stop on curtain");
  chk_release_stop: assert property (O_CLUTCH_ENGAGE && !both |=> !O_CLUTCH_ENGAGE)
    else $error("no stop on release");
  // reset in the antecedent: the lamp flop still sees reset on the release edge
  chk_inch_led: assert property (!I_RESET && I_MODE_INCH && !I_MODE_SINGLE |=> O_INCH_LED)
    else $error("inch lamp off");
  chk_overrun_code: assert property (I_OVERRUN && !stop && !O_FAULT_ACTIVE
    |=> O_FAULT_CODE == OVERRUN_FAULT_CODE_LOW) else $error("overrun code missing");
  chk_fault_hold: assert property (O_FAULT_ACTIVE && !I_RESET_SELECT && !stop
    |=> $stable(O_FAULT_CODE)) else $error("fault code moved");

  // main scenarios seen
  cov_stroke: cover property ($rose(O_CLUTCH_ENGAGE));
  cov_curtain: cover property (O_CLUTCH_ENGAGE && I_DOWNSTROKE && blocked);
  cov_clear: cover property (O_FAULT_ACTIVE && I_RESET_SELECT ##1 !O_FAULT_ACTIVE);
endmodule : pssc_checker

bind pssc_core pssc_checker pssc_checker_inst (.*);

//--- bench/tb.sv
// self-checking bench for the press stroke safety control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
  import pssc_pkg::*;
  localparam int unsigned FH = 4;  // short flash so a blink fits in a few cycles
  logic I_CLK_SYS = 1'b0;
  logic I_RESET = 1'b1;
  logic I_MODE_INCH, I_MODE_SINGLE, I_MODE_REPEAT, I_ESTOP_CH1, I_ESTOP_CH2, I_CLUTCH_AIR_OK;
  logic I_USER_IN1_OK, I_CURTAIN_A_CH1, I_CURTAIN_A_CH2, I_CURTAIN_B_CH1, I_CURTAIN_B_CH2;
  logic I_RUN_LEFT, I_RUN_RIGHT, I_RESET_SELECT, I_AT_TDC, I_DOWNSTROKE, I_OVERRUN;
  logic I_AVS_READ, I_AVS_WRITE, O_AVS_WAITREQUEST, O_CLUTCH_ENGAGE, O_INTERRUPTED_LED;
  logic O_INCH_LED, O_SINGLE_LED, O_FAULT_ALT, O_FAULT_ACTIVE, l0;
  logic [AVS_ADDR_W-1:0] I_AVS_ADDRESS;
  logic [31:0] I_AVS_WRITEDATA, O_AVS_READDATA, q, exp_ctrl;
  logic [3:0] I_AVS_BYTEENABLE;
  logic [7:0] O_FAULT_CODE;
  logic [7:0] ec [4] = '{CLUTCH_AIR_FAULT_CODE, USER_INPUT_ONE_FAULT_CODE,
                        ESTOP_FAULT_CODE, ESTOP_FAULT_CODE};
  int mismatches = 0;
  int total_checks = 0;
  int k, n;
  logic creep = 1'b0;

  pssc_core #(.FLASH_HALF_CYCLES(FH)) pssc_core_inst (.*);
  pssc_ram_model pssc_ram_model_inst (.i_clk(I_CLK_SYS), .i_rst(I_RESET),
    .i_clutch(O_CLUTCH_ENGAGE), .i_creep(creep), .o_at_tdc(I_AT_TDC),
    .o_downstroke(I_DOWNSTROKE));

  always #2.5 I_CLK_SYS = ~I_CLK_SYS;

  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int c);
    repeat (c) @(posedge I_CLK_SYS);
  endtask : cyc

  task automatic run(input logic v);
    I_RUN_LEFT <= v;
    I_RUN_RIGHT <= v;
  endtask : run

  // one bus access held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge I_CLK_SYS);
    I_AVS_ADDRESS <= a;
    I_AVS_WRITE <= wr;
    I_AVS_READ <= !wr;
    I_AVS_WRITEDATA <= d;
    // waitrequest and read data are taken at the rising edge, before it updates them
    do @(posedge I_CLK_SYS); while (O_AVS_WAITREQUEST !== 1'b0);
    q = O_AVS_READDATA;
    I_AVS_READ <= 1'b0;
    I_AVS_WRITE <= 1'b0;
  endtask : bus

  task automatic wt(input logic v);
    n = 0;
    do begin @(negedge I_CLK_SYS); n++; end while (O_CLUTCH_ENGAGE !== v && n < 100);
    `CHK("clutch", v, O_CLUTCH_ENGAGE)
    cyc(1);
  endtask : wt

  // counts lamp changes; a stuck lamp shows no change
  task automatic flash;
    n = 0;
    @(negedge I_CLK_SYS);
    l0 = O_INTERRUPTED_LED;
    repeat (3 * FH) begin
      @(negedge I_CLK_SYS);
      if (O_INTERRUPTED_LED !== l0) n++;
      l0 = O_INTERRUPTED_LED;
    end
    `CHK("flash", 1'b1, n >= 2)
    cyc(1);
  endtask : flash

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // watchdog far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {I_MODE_SINGLE, I_MODE_REPEAT, I_RUN_LEFT, I_RUN_RIGHT, I_RESET_SELECT, I_OVERRUN} = '0;
    {I_AVS_READ, I_AVS_WRITE, I_AVS_ADDRESS, I_AVS_WRITEDATA} = '0;
    {I_MODE_INCH, I_ESTOP_CH1, I_ESTOP_CH2, I_CLUTCH_AIR_OK, I_USER_IN1_OK} = '1;
    {I_CURTAIN_A_CH1, I_CURTAIN_A_CH2, I_CURTAIN_B_CH1, I_CURTAIN_B_CH2} = '1;
    I_AVS_BYTEENABLE = 4'hF;
    void'($urandom(32'h5297CCEB));
    cyc(5);
    I_RESET <= 1'b0;
    cyc(2);
    @(negedge I_CLK_SYS);
    `CHK("inch lamp", 1'b1, O_INCH_LED)
    `CHK("int lamp", 1'b1, O_INTERRUPTED_LED)
    bus(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, q)
    bus(1'b0, 4'hC, 32'h0);
    `CHK("unmapped", 32'h0, q)
    exp_ctrl = 32'h1 | ($urandom() & 32'h2);
    bus(1'b1, REG_CTRL, exp_ctrl);
    bus(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl", exp_ctrl, q)
    // single stroke, then hold on to prove no repeat
    I_MODE_INCH <= 1'b0;
    I_MODE_SINGLE <= 1'b1;
    run(1'b1);
    wt(1'b1);
    wt(1'b0);
    cyc(30);
    @(negedge I_CLK_SYS);
    `CHK("top", 1'b1, I_AT_TDC)
    `CHK("repeat", 1'b0, O_CLUTCH_ENGAGE)
    `CHK("single lamp", 1'b1, O_SINGLE_LED)
    cyc(1);
    run(1'b0);
    bus(1'b0, REG_COUNT, 32'h0);
    `CHK("count", 32'h1, q)
    // air, user input one and each e-stop channel lost in turn: code latched, held, cleared only once healthy
    for (k = 0; k < 4; k++) begin
      cyc(1);
      case (k)
        0: I_CLUTCH_AIR_OK <= 1'b0;
        1: I_USER_IN1_OK <= 1'b0;
        2: I_ESTOP_CH1 <= 1'b0;
        default: I_ESTOP_CH2 <= 1'b0;
      endcase
      run(1'b1);
      cyc(4);
      @(negedge I_CLK_SYS);
      `CHK("code", ec[k], O_FAULT_CODE)
      `CHK("clutch", 1'b0, O_CLUTCH_ENGAGE)
      // idle, clutch off, fault flag, code in bits 15:8
      bus(1'b0, REG_STATUS, 32'h0);
      `CHK("status", {16'h0, ec[k], 8'h10}, q)
      cyc(1);
      run(1'b0);
      I_RESET_SELECT <= 1'b1;
      cyc(2);
      @(negedge I_CLK_SYS);
      `CHK("held", ec[k], O_FAULT_CODE)
      cyc(1);
      {I_CLUTCH_AIR_OK, I_USER_IN1_OK, I_ESTOP_CH1, I_ESTOP_CH2} <= '1;
      cyc(2);
      @(negedge I_CLK_SYS);
      `CHK("cleared", FAULT_NONE, O_FAULT_CODE)
      cyc(1);
      I_RESET_SELECT <= 1'b0;
    end
    // blocked curtain at rest, then blocked on the downstroke, each curtain alone
    for (k = 0; k < 2; k++) begin
      cyc(1);
      if (k == 0) I_CURTAIN_A_CH2 <= 1'b0; else I_CURTAIN_B_CH1 <= 1'b0;
      run(1'b1);
      cyc(5);
      @(negedge I_CLK_SYS);
      `CHK("blocked", 1'b0, O_CLUTCH_ENGAGE)
      cyc(1);
      {I_CURTAIN_A_CH2, I_CURTAIN_B_CH1} <= '1;
      run(1'b0);
      cyc(2);
      run(1'b1);
      do @(negedge I_CLK_SYS); while (!I_DOWNSTROKE);
      cyc(1);
      if (k == 0) I_CURTAIN_A_CH1 <= 1'b0; else I_CURTAIN_B_CH2 <= 1'b0;
      cyc(1);
      @(negedge I_CLK_SYS);
      `CHK("stop", 1'b0, O_CLUTCH_ENGAGE)
      flash();
      {I_CURTAIN_A_CH1, I_CURTAIN_B_CH2} <= '1;
      run(1'b0);
      cyc(2);
      run(1'b1);
      wt(1'b1);
      wt(1'b0);
      @(negedge I_CLK_SYS);
      `CHK("top", 1'b1, I_AT_TDC)
      if (k == 1) begin
        // brake slips while parked with buttons held: a failed top stop
        cyc(1);
        creep <= 1'b1;
        cyc(1);
        creep <= 1'b0;
        cyc(1);
        @(negedge I_CLK_SYS);
        `CHK("creep", OVERRUN_FAULT_CODE_STOP, O_FAULT_CODE)
      end
      cyc(1);
      run(1'b0);
    end
    // the creep code clears once the sequencer has left the parked state
    I_RESET_SELECT <= 1'b1;
    cyc(2);
    I_RESET_SELECT <= 1'b0;
    @(negedge I_CLK_SYS);
    `CHK("creep clear", FAULT_NONE, O_FAULT_CODE)
    // overrun sensor fault and its display range
    cyc(1);
    I_OVERRUN <= 1'b1;
    cyc(1);
    I_OVERRUN <= 1'b0;
    @(negedge I_CLK_SYS);
    `CHK("overrun", OVERRUN_FAULT_CODE_LOW, O_FAULT_CODE)
    `CHK("alt", exp_ctrl[1], O_FAULT_ALT)
    cyc(1);
    I_RESET_SELECT <= 1'b1;
    cyc(2);
    I_RESET_SELECT <= 1'b0;
    // hold-to-run: short press, release, lamp blinks
    I_MODE_SINGLE <= 1'b0;
    I_MODE_INCH <= 1'b1;
    cyc(2);
    run(1'b1);
    wt(1'b1);
    cyc(2);
    run(1'b0);
    cyc(1);
    @(negedge I_CLK_SYS);
    `CHK("inch stop", 1'b0, O_CLUTCH_ENGAGE)
    flash();
    end_sim();
  end
endmodule : tb
